// ==== logic/drs_pkg.sv ====
// Purpose: Shared constants and carriers for the row and refresh scheduler
// Assumes: 25 MHz core clock, command pins sampled on its rising edge
// Notes:   Row, refresh and repair status behaviour of the memory device
//
// Functional notes
// - Self-test outcome 10 means unrepairable, 11 means leftover repairable
// - Status bits clear on power-up or on the active-low reset pin
// - Outcome field stays zero when self-test finds nothing; host tracks runs
// - Feature flags: page-2 bit7 hard, bit6 soft; page-3 bit7 self-test repair
// - Activate opens the addressed row in the chosen bank until precharge
// - Precharge to idle or precharging bank accepted; latest one sets timing
// - Read or write with auto_precharge_bit high closes bank after restore
// - Refresh decoded on select, row and column strobes low, write high
// - Refresh rows come from an internal counter; all banks idle afterwards
// - Mode word four bit 3 enables temperature refresh; bit 2 zero is normal
// - Temperature refresh counts each refresh while control bit 0 (hot) is set; while it is clear, skips some at a ratio set by control bits 2:1
// - Mode word three bits 8:6 select fixed or on-the-fly refresh rate
package drs_pkg;
  localparam int CLK_NS     = 40;
  localparam int PRE_NS     = 15;
  localparam int TRFC1_NS   = 350;
  localparam int TRFC2_NS   = 260;
  localparam int TRFC4_NS   = 160;
  localparam logic [3:0] PRE_CYC   = 4'((PRE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] TRFC1_CYC = 4'((TRFC1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] TRFC2_CYC = 4'((TRFC2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] TRFC4_CYC = 4'((TRFC4_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] AP_RD_CYC = 3'h2;
  localparam logic [2:0] AP_WR_CYC = 3'h4;

  localparam logic [2:0] RATE_1X    = 3'h0;
  localparam logic [2:0] RATE_2X    = 3'h1;
  localparam logic [2:0] RATE_4X    = 3'h2;
  localparam logic [2:0] RATE_OTF12 = 3'h5;
  localparam logic [2:0] RATE_OTF14 = 3'h6;
  localparam logic [15:0] STEP_1X   = 16'h0004;
  localparam logic [15:0] STEP_2X   = 16'h0002;
  localparam logic [15:0] STEP_4X   = 16'h0001;

  localparam logic [3:0] MW3_SEL    = 4'h3;
  localparam logic [3:0] MW4_SEL    = 4'h4;
  localparam int MW4_TREF_BIT       = 3;
  localparam int MW4_RANGE_BIT      = 2;
  localparam int AP_BIT             = 10;

  localparam logic [3:0] REG_FEAT   = 4'h0;
  localparam logic [3:0] REG_STAT   = 4'h1;
  localparam logic [3:0] REG_CTRL   = 4'h2;
  localparam logic [3:0] REG_OPEN_L = 4'h3;
  localparam logic [3:0] REG_OPEN_H = 4'h4;
  localparam logic [3:0] REG_REFROW = 4'h5;
  localparam logic [3:0] REG_MODE   = 4'h6;
  localparam logic [3:0] REG_PROBE  = 4'h7;
  localparam logic [3:0] REG_ROW_L  = 4'h8;
  localparam logic [3:0] REG_ROW_M  = 4'h9;
  localparam logic [3:0] REG_ROW_H  = 4'ha;
  localparam logic [7:0] CTRL_RST   = 8'h02;
  localparam int CTRL_HOT_BIT       = 0;
  localparam int ST_CODE_LSB        = 4;

  localparam logic [1:0] ST_NONE     = 2'h0;
  localparam logic [1:0] ST_REPAIRED = 2'h1;
  localparam logic [1:0] ST_UNREP    = 2'h2;
  localparam logic [1:0] ST_AGAIN    = 2'h3;

  typedef struct packed {
    logic        cs_n;
    logic        act_n;
    logic [1:0]  bank_group_inputs;
    logic [1:0]  bank_inputs;
    logic        row_strobe_pin;
    logic        column_strobe_pin;
    logic        write_enable_pin;
    logic        addr_17;
    logic [13:0] addr_lo;
  } drs_cmd_type;

  localparam drs_cmd_type CMD_IDLE = 24'hffffff;
endpackage

// ==== logic/drs_sync.sv ====
// Purpose: Two-flop synchroniser for a bundle of pin levels
// Assumes: Each bit is an independent slow level or a setup-met bus
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
module drs_sync #(
  parameter int               W    = 1,
  parameter logic [W-1:0]     INIT = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } drs_sync_type;

  drs_sync_type st_ff;
  drs_sync_type nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= {INIT, INIT};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;
endmodule

// ==== logic/drs_row_mem.sv ====
// Purpose: Open-row table, one entry per bank
// Assumes: One write and one read per cycle
// Notes:   Read data registered, so it trails the read address by one cycle
`timescale 1ns/1ns
module drs_row_mem #(
  parameter int DEPTH = 16,
  parameter int AW    = 4,
  parameter int W     = 18
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  // Read side
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] rd_ff;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Only the read register resets; unwritten entries read back undefined
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ff <= '0;
    end else begin
      rd_ff <= mem[rd_addr];
    end
  end

  assign rd_data = rd_ff;
endmodule

// ==== logic/drs_core.sv ====
// Purpose: Bank open/precharge tracking, refresh engine, repair status words
// Assumes: Controller keeps all command spacing; pins arrive asynchronously
// Notes:   Commands act two cycles after the pins because of synchronisers
`timescale 1ns/1ns
module drs_core #(
  parameter logic HARD_AVAIL = 1'b1,
  parameter logic SOFT_AVAIL = 1'b1,
  parameter logic BIST_AVAIL = 1'b1
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Command pins
  input  wire drs_pkg::drs_cmd_type cmd_pin,
  input  wire logic               reset_n_pin,
  // Self-test engine result
  input  wire logic               selftest_done,
  input  wire logic [1:0]         selftest_code,
  // Register port
  input  wire logic [3:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  // Status
  output logic      [15:0]        bank_open,
  output logic                    refresh_busy,
  output logic                    internal_refresh,
  output logic      [15:0]        refresh_row
);
  import drs_pkg::*;

  typedef struct packed {
    logic [2:0]        rate;
    logic              tref_en;
    logic              tref_range;
    logic [7:0]        ctrl;
    logic [3:0]        probe;
    logic [15:0]       open;
    logic [15:0][3:0]  pre_cnt;
    logic [15:0]       ap_pend;
    logic [15:0][2:0]  ap_cnt;
    logic [3:0]        last_bank;
    logic              ref_busy;
    logic [3:0]        ref_cnt;
    logic [15:0]       ref_row;
    logic [1:0]        gear;
    logic              int_ref;
    logic [15:0]       ext_refs;
    logic [1:0]        st_code;
    logic [7:0]        rdata;
  } drs_core_type;

  localparam drs_core_type CORE_RST = '{ctrl: CTRL_RST, default: '0};

  drs_core_type st_ff;
  drs_core_type nxt_st;
  drs_cmd_type  c;
  logic         rn;
  logic [17:0]  row_addr;
  logic [17:0]  probe_row;
  logic [3:0]   bidx;
  logic [2:0]   rcw;
  logic         is_act;
  logic         is_ref;
  logic         is_pre;
  logic         is_rd;
  logic         is_wr;
  logic         is_mrs;
  logic         tref_skip;
  logic [2:0]   mrs_code;

  drs_sync #(.W(24), .INIT(CMD_IDLE)) u_cmd_sync (
    .clk (clk),
    .rst (rst),
    .d   (cmd_pin),
    .q   (c)
  );

  drs_sync #(.W(1), .INIT(1'b1)) u_rst_sync (
    .clk (clk),
    .rst (rst),
    .d   (reset_n_pin),
    .q   (rn)
  );

  drs_row_mem #(.DEPTH(16), .AW(4), .W(18)) u_rows (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (is_act),
    .wr_addr (bidx),
    .wr_data (row_addr),
    .rd_addr (st_ff.probe),
    .rd_data (probe_row)
  );

  // Command decode; strobe pins double as row address bits on activate
  assign bidx     = {c.bank_group_inputs, c.bank_inputs};
  assign rcw      = {c.row_strobe_pin, c.column_strobe_pin,
                     c.write_enable_pin};
  assign row_addr = {c.addr_17, rcw, c.addr_lo};
  assign is_act   = !c.cs_n && !c.act_n;
  assign is_ref   = !c.cs_n && c.act_n && rcw == 3'b001;
  assign is_pre   = !c.cs_n && c.act_n && rcw == 3'b010;
  assign is_rd    = !c.cs_n && c.act_n && rcw == 3'b101;
  assign is_wr    = !c.cs_n && c.act_n && rcw == 3'b100;
  assign is_mrs   = !c.cs_n && c.act_n && rcw == 3'b000;
  assign mrs_code = c.addr_lo[8:6];
  // Hot case forces every refresh to be done internally
  assign tref_skip = st_ff.tref_en && !st_ff.ctrl[CTRL_HOT_BIT] &&
                     st_ff.gear != 2'h0;

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.int_ref = 1'b0;
    nxt_st.rdata   = 8'h00;

    for (int b = 0; b < 16; b++) begin
      if (st_ff.pre_cnt[b] != 4'h0) begin
        nxt_st.pre_cnt[b] = st_ff.pre_cnt[b] - 4'h1;
      end
      // Lockout: precharge waits for restore or write storage
      if (st_ff.ap_pend[b]) begin
        if (st_ff.ap_cnt[b] == 3'h0) begin
          nxt_st.ap_pend[b] = 1'b0;
          nxt_st.open[b]    = 1'b0;
          nxt_st.pre_cnt[b] = PRE_CYC;
        end else begin
          nxt_st.ap_cnt[b] = st_ff.ap_cnt[b] - 3'h1;
        end
      end
    end

    if (st_ff.ref_busy) begin
      nxt_st.ref_cnt = st_ff.ref_cnt - 4'h1;
      if (st_ff.ref_cnt == 4'h1) begin
        nxt_st.ref_busy = 1'b0;
        nxt_st.open     = '0;
      end
    end

    if (is_act) begin
      nxt_st.open[bidx]  = 1'b1;
      nxt_st.last_bank   = bidx;
    end else if (is_pre) begin
      nxt_st.last_bank = bidx;
      if (c.addr_lo[AP_BIT]) begin
        nxt_st.open    = '0;
        nxt_st.ap_pend = '0;
        for (int b = 0; b < 16; b++) begin
          nxt_st.pre_cnt[b] = PRE_CYC;
        end
      end else begin
        nxt_st.open[bidx]    = 1'b0;
        nxt_st.ap_pend[bidx] = 1'b0;
        nxt_st.pre_cnt[bidx] = PRE_CYC;
      end
    end else if ((is_rd || is_wr) && c.addr_lo[AP_BIT]) begin
      nxt_st.last_bank     = bidx;
      nxt_st.ap_pend[bidx] = 1'b1;
      nxt_st.ap_cnt[bidx]  = is_wr ? AP_WR_CYC : AP_RD_CYC;
    end else if (is_ref) begin
      nxt_st.ext_refs = st_ff.ext_refs + 16'h0001;
      nxt_st.ref_busy = 1'b1;
      if (st_ff.tref_en && !st_ff.ctrl[CTRL_HOT_BIT]) begin
        nxt_st.gear = (st_ff.gear >= st_ff.ctrl[2:1]) ? 2'h0
                                                      : st_ff.gear + 2'h1;
      end
      // Rate from mode word; on-the-fly picks by bank group bit 0
      if (st_ff.rate == RATE_2X ||
          (st_ff.rate == RATE_OTF12 && c.bank_group_inputs[0])) begin
        nxt_st.ref_cnt = TRFC2_CYC;
        if (!tref_skip) begin
          nxt_st.ref_row = st_ff.ref_row + STEP_2X;
        end
      end else if (st_ff.rate == RATE_4X ||
                   (st_ff.rate == RATE_OTF14 &&
                    c.bank_group_inputs[0])) begin
        nxt_st.ref_cnt = TRFC4_CYC;
        if (!tref_skip) begin
          nxt_st.ref_row = st_ff.ref_row + STEP_4X;
        end
      end else begin
        nxt_st.ref_cnt = TRFC1_CYC;
        if (!tref_skip) begin
          nxt_st.ref_row = st_ff.ref_row + STEP_1X;
        end
      end
      nxt_st.int_ref = !tref_skip;
    end else if (is_mrs) begin
      if (bidx == MW3_SEL && (mrs_code == RATE_1X ||
          mrs_code == RATE_2X || mrs_code == RATE_4X ||
          mrs_code == RATE_OTF12 || mrs_code == RATE_OTF14)) begin
        nxt_st.rate = mrs_code;
      end else if (bidx == MW4_SEL) begin
        nxt_st.tref_en    = c.addr_lo[MW4_TREF_BIT];
        nxt_st.tref_range = c.addr_lo[MW4_RANGE_BIT];
        nxt_st.gear      = 2'h0;
      end
    end

    // Zero stays for a clean run as well as for no run at all
    if (selftest_done) begin
      nxt_st.st_code = selftest_code;
    end
    // Pin reset wins over a result landing in the same cycle
    if (!rn) begin
      nxt_st.st_code = ST_NONE;
      nxt_st.open    = '0;
      nxt_st.ap_pend = '0;
    end

    if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        nxt_st.ctrl = reg_wdata;
      end else if (reg_addr == REG_PROBE) begin
        nxt_st.probe = reg_wdata[3:0];
      end
    end

    if (reg_rd) begin
      if (reg_addr == REG_FEAT) begin
        nxt_st.rdata = {HARD_AVAIL, SOFT_AVAIL, 6'h00};
      end else if (reg_addr == REG_STAT) begin
        nxt_st.rdata = {BIST_AVAIL, 1'b0, st_ff.st_code, 4'h0};
      end else if (reg_addr == REG_CTRL) begin
        nxt_st.rdata = st_ff.ctrl;
      end else if (reg_addr == REG_OPEN_L) begin
        nxt_st.rdata = st_ff.open[7:0];
      end else if (reg_addr == REG_OPEN_H) begin
        nxt_st.rdata = st_ff.open[15:8];
      end else if (reg_addr == REG_REFROW) begin
        nxt_st.rdata = st_ff.ref_row[7:0];
      end else if (reg_addr == REG_MODE) begin
        nxt_st.rdata = {st_ff.ref_busy, 2'h0, st_ff.tref_en,
                        st_ff.tref_range, st_ff.rate};
      end else if (reg_addr == REG_PROBE) begin
        nxt_st.rdata = {4'h0, st_ff.probe};
      end else if (reg_addr == REG_ROW_L) begin
        nxt_st.rdata = probe_row[7:0];
      end else if (reg_addr == REG_ROW_M) begin
        nxt_st.rdata = probe_row[15:8];
      end else if (reg_addr == REG_ROW_H) begin
        nxt_st.rdata = {6'h00, probe_row[17:16]};
      end else begin
        nxt_st.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= CORE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata        = st_ff.rdata;
  assign bank_open        = st_ff.open;
  assign refresh_busy     = st_ff.ref_busy;
  assign internal_refresh = st_ff.int_ref;
  assign refresh_row      = st_ff.ref_row;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence rd_ap_s;
    is_rd && c.addr_lo[AP_BIT] && !is_pre;
  endsequence

  sequence ap_done_s;
    st_ff.ap_pend[st_ff.last_bank] && st_ff.ap_cnt[st_ff.last_bank] == 3'h0;
  endsequence

  act_opens_row_a: assert property (
    is_act && rn |=> st_ff.open[st_ff.last_bank])
    else $error("activate did not open bank");

  pre_restart_a: assert property (
    is_pre && !c.addr_lo[AP_BIT] |=>
      st_ff.pre_cnt[st_ff.last_bank] == PRE_CYC &&
      !st_ff.open[st_ff.last_bank])
    else $error("precharge timer not restarted");

  ap_arm_a: assert property (
    rd_ap_s |=> st_ff.ap_pend[st_ff.last_bank] &&
               st_ff.ap_cnt[st_ff.last_bank] == AP_RD_CYC)
    else $error("read auto precharge not armed");

  ap_close_a: assert property (
    ap_done_s and !is_act |=> !st_ff.open[$past(st_ff.last_bank)])
    else $error("auto precharge did not close bank");

  ref_count_a: assert property (
    is_ref |=> st_ff.ref_busy &&
               st_ff.ext_refs == $past(st_ff.ext_refs) + 16'h0001)
    else $error("refresh not registered");

  ref_idle_a: assert property (
    st_ff.ref_busy && st_ff.ref_cnt == 4'h1 && !is_act |=>
      !st_ff.ref_busy && st_ff.open == 16'h0000)
    else $error("banks not idle after refresh");

  outcome_code_a: assert property (
    selftest_done && rn |=> st_ff.st_code == $past(selftest_code))
    else $error("self-test outcome not stored");

  pin_clear_a: assert property (
    !rn |=> st_ff.st_code == ST_NONE)
    else $error("status not cleared by pin reset");

  feat_flags_a: assert property (
    reg_rd && reg_addr == REG_FEAT |=>
      reg_rdata == {HARD_AVAIL, SOFT_AVAIL, 6'h00} ##1
      (reg_rdata == 8'h00 || $past(reg_rd)))
    else $error("feature flags wrong");

  tref_mode_a: assert property (
    is_mrs && bidx == MW4_SEL |=>
      st_ff.tref_en == $past(c.addr_lo[MW4_TREF_BIT]))
    else $error("temperature refresh enable wrong");

  tref_skip_a: assert property (
    is_ref && tref_skip |=> !internal_refresh && $stable(refresh_row))
    else $error("skipped refresh still performed");

  rate_reserved_a: assert property (
    is_mrs && bidx == MW3_SEL && mrs_code == 3'h7 |=> $stable(st_ff.rate))
    else $error("reserved rate code accepted");
endmodule

// ==== bench/drs_ctl_model.sv ====
// Purpose: Memory controller model driving the command pins
// Assumes: Bench calls its tasks one at a time
// Notes:   Deselected pins show the inverse of the last command
`timescale 1ns/1ns
module drs_ctl_model #(
  parameter int GAP_RRD = 4,
  parameter int GAP_RP  = 2,
  parameter int GAP_REF = 30
) (
  // Clock
  input  wire logic             clk,
  // Command pins towards the device
  output drs_pkg::drs_cmd_type  cmd
);
  import drs_pkg::*;
  int          cyc = 0;
  int          ready_at = 0;
  logic [15:0] open_rec = '0;

  initial cmd = CMD_IDLE;
  always @(posedge clk) cyc <= cyc + 1;

  function automatic drs_cmd_type mk(input logic [3:0] b, input logic act,
    input logic [2:0] rcw, input logic a17, input logic [13:0] lo);
    mk = {1'b0, ~act, b, rcw, a17, lo};
  endfunction

  // Spacing kept by waiting out the previous command's gap
  task automatic issue(input drs_cmd_type c, input int gap);
    drs_cmd_type idle;
    while (cyc < ready_at) @(posedge clk);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    idle = ~c;
    idle.cs_n = 1'b1;
    cmd <= idle;
    ready_at = cyc + gap;
  endtask

  task automatic pre(input logic [3:0] b, input logic all);
    issue(mk(b, 1'b0, 3'h2, 1'b0, {3'h0, all, 10'h0}), GAP_RP);
    if (all) open_rec = '0;
    else open_rec[b] = 1'b0;
  endtask

  // Gap wide enough that any four activates fill the window
  task automatic act(input logic [3:0] b, input logic [17:0] row);
    if (open_rec[b]) pre(b, 1'b0);
    issue(mk(b, 1'b1, row[16:14], row[17], row[13:0]), GAP_RRD);
    open_rec[b] = 1'b1;
  endtask

  task automatic col(input logic [3:0] b, input logic w, input logic ap);
    issue(mk(b, 1'b0, {2'h2, ~w}, 1'b0, {3'h0, ap, 10'h0}), GAP_RRD);
    if (ap) open_rec[b] = 1'b0;
  endtask

  task automatic mrs(input logic [3:0] sel, input logic [13:0] lo);
    issue(mk(sel, 1'b0, 3'h0, 1'b0, lo), GAP_RP);
  endtask

  // Wide refresh gap keeps pull-in bursts inside the window limits
  task automatic refresh(input logic [31:0] noise);
    pre(4'h0, 1'b1);
    issue(mk(noise[3:0], 1'b0, 3'h1, noise[4], noise[18:5]),
          GAP_REF);
  endtask
endmodule

// ==== bench/test_dram_row_refresh_scheduling.sv ====
// Purpose: Self-checking bench for the row and refresh scheduler
// Assumes: Controller model keeps all command spacing
// Notes:   Outputs checked three edges after the command is sampled
`timescale 1ns/1ns
module test_dram_row_refresh_scheduling;
  import drs_pkg::*;
  localparam logic HARD = 1'b1;
  localparam logic SOFT = 1'b0;
  localparam logic BIST = 1'b1;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  drs_cmd_type  cmd;
  logic         reset_n_pin = 1'b1;
  logic         selftest_done = 1'b0;
  logic [1:0]   selftest_code = 2'h0;
  logic [3:0]   reg_addr = 4'h0;
  logic [7:0]   reg_wdata = 8'h00;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [7:0]   reg_rdata;
  logic [15:0]  bank_open;
  logic         refresh_busy;
  logic         internal_refresh;
  logic [15:0]  refresh_row;
  int           err_total = 0;
  int           tests_run = 0;
  logic [7:0]   rv;
  logic [15:0]  exp_open;
  logic [2:0]   exp_rate;
  logic [3:0]   b;
  logic [17:0]  r;
  logic [15:0]  d;
  logic         ir;
  int           n;
  int           npl;

  always #20 clk = ~clk;

  drs_ctl_model ctl (.clk(clk), .cmd(cmd));
  drs_core #(.HARD_AVAIL(HARD), .SOFT_AVAIL(SOFT), .BIST_AVAIL(BIST)) dut (
    .clk(clk), .rst(rst), .cmd_pin(cmd), .reset_n_pin(reset_n_pin),
    .selftest_done(selftest_done), .selftest_code(selftest_code),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bank_open(bank_open),
    .refresh_busy(refresh_busy), .internal_refresh(internal_refresh),
    .refresh_row(refresh_row));

  function automatic logic [7:0] st_word(input logic [1:0] c);
    st_word = {BIST, 1'b0, c, 4'h0};
  endfunction
  function automatic logic [15:0] step_of(input logic [2:0] m);
    step_of = (m == RATE_2X) ? STEP_2X : (m == RATE_4X) ? STEP_4X : STEP_1X;
  endfunction
  function automatic int refresh_cycle_time_of(input logic [2:0] m);
    refresh_cycle_time_of = (m == RATE_2X) ? TRFC2_CYC : (m == RATE_4X) ? TRFC4_CYC
      : TRFC1_CYC;
  endfunction

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] q);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= q;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [3:0] a,
    input logic [7:0] e);
    rd(a, rv);
    chk(what, rv, e);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic st_pulse(input logic [1:0] c);
    @(posedge clk);
    selftest_done <= 1'b1;
    selftest_code <= c;
    @(posedge clk);
    selftest_done <= 1'b0;
  endtask
  // Random address bits on the refresh must not matter
  task automatic do_ref(output logic pl, output int len,
    output logic [15:0] st);
    logic [15:0] r0;
    r0 = refresh_row;
    ctl.refresh($urandom);
    // Pulse stands only on the third edge after the pins
    repeat (2) @(posedge clk);
    #1;
    pl = internal_refresh;
    st = refresh_row - r0;
    len = 0;
    while (refresh_busy === 1'b1 && len < 40) begin
      len++;
      @(posedge clk);
      #1;
      if (len == 1) chk("pulse end", internal_refresh, 1'b0);
    end
    chk("idle after refresh", bank_open, 16'h0000);
  endtask

  initial begin
    #(40 * 60000);
    err_total++;
    results();
  end

  initial begin
    void'($urandom(39));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rchk("features", REG_FEAT, {HARD, SOFT, 6'h0});
    rchk("ctrl reset", REG_CTRL, CTRL_RST);
    wr(REG_FEAT, 8'h00);
    rchk("features ro", REG_FEAT, {HARD, SOFT, 6'h0});
    for (int a = 11; a < 16; a++) begin
      rchk("unmapped", 4'(a), 8'h00);
    end
    rchk("status reset", REG_STAT, st_word(ST_NONE));
    for (int c = 3; c >= 0; c--) begin
      st_pulse(2'(c));
      rchk("status code", REG_STAT, st_word(2'(c)));
    end
    exp_open = '0;
    for (int i = 0; i < 8; i++) begin
      b = 4'($urandom);
      r = (i == 0) ? 18'h0 : (i == 1) ? 18'h3ffff : 18'($urandom);
      ctl.act(b, r);
      exp_open[b] = 1'b1;
      settle();
      chk("bank open", bank_open, exp_open);
      wr(REG_PROBE, {4'h0, b});
      rchk("row low", REG_ROW_L, r[7:0]);
      rchk("row mid", REG_ROW_M, r[15:8]);
      rchk("row high", REG_ROW_H, {6'h0, r[17:16]});
    end
    rchk("open low", REG_OPEN_L, exp_open[7:0]);
    rchk("open high", REG_OPEN_H, exp_open[15:8]);
    ctl.pre(b, 1'b0);
    ctl.pre(b, 1'b0);
    ctl.pre(~b, 1'b0);
    exp_open[b] = 1'b0;
    exp_open[~b] = 1'b0;
    settle();
    chk("precharge", bank_open, exp_open);
    for (int k = 0; k < 3; k++) begin
      ctl.act(b, 18'($urandom));
      settle();
      ctl.col(b, k == 2, k != 0);
      repeat ((k == 2) ? 6 : 4) @(posedge clk);
      #1;
      chk("ap wait", bank_open[b], 1'b1);
      @(posedge clk);
      #1;
      chk("ap done", bank_open[b], k == 0);
    end
    exp_rate = RATE_1X;
    for (int m = 0; m < 8; m++) begin
      ctl.mrs(MW3_SEL, 14'({m, 6'h0}));
      if (m inside {0, 1, 2, 5, 6}) exp_rate = 3'(m);
      settle();
      rchk("rate mode", REG_MODE, {5'h0, exp_rate});
    end
    for (int m = 0; m < 3; m++) begin
      ctl.mrs(MW3_SEL, 14'({m, 6'h0}));
      do_ref(ir, n, d);
      chk("refresh pulse", ir, 1'b1);
      chk("row step", d, step_of(3'(m)));
      chk("busy length", n, refresh_cycle_time_of(3'(m)));
    end
    ctl.mrs(MW3_SEL, 14'h0);
    ctl.mrs(MW4_SEL, 14'h0008);
    settle();
    rchk("temp mode", REG_MODE, 8'h10);
    for (int h = 0; h < 2; h++) begin
      if (h == 1) wr(REG_CTRL, CTRL_RST | 8'h01);
      npl = 0;
      for (int i = 0; i < 4; i++) begin
        do_ref(ir, n, d);
        if (ir === 1'b1) npl++;
        chk("temp busy", n, TRFC1_CYC);
      end
      chk("temp pulses", npl, (h == 1) ? 4 : 2);
    end
    ctl.mrs(MW4_SEL, 14'h0);
    st_pulse(ST_UNREP);
    ctl.act(4'h5, 18'($urandom));
    settle();
    @(posedge clk);
    reset_n_pin <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n_pin <= 1'b1;
    settle();
    chk("pin reset open", bank_open, 16'h0000);
    rchk("pin reset status", REG_STAT, st_word(ST_NONE));
    rchk("pin reset mode", REG_MODE, 8'h00);
    results();
  end
endmodule
